// File: hw/stop_exit_cfg.svh
`ifndef STOP_EXIT_CFG_SVH
`define STOP_EXIT_CFG_SVH
// register byte offsets
`define OFF_CTRL 12'h000
`define OFF_STATUS 12'h004
`define OFF_IRQ_STAT 12'h008
`define OFF_IRQ_EN 12'h00c
`define OFF_IRQ_CLR 12'h010
`define OFF_CMD 12'h014
// control field positions
`define CTRL_FALLBACK_DISABLE 0
`define CTRL_MONITOR_ENABLE 1
`define CTRL_FORCED_MONITOR 2
`define CTRL_EXIT_DELAY 3
`define CTRL_OSC_HOLD 4
`define CTRL_SLOW_LSB 8
`define CTRL_SLOW_MSB 13
// command field positions (write one to trigger; only CMD_STOP is decoded, CMD_FLAG_CLR does nothing)
`define CMD_STOP 0
`define CMD_FLAG_CLR 1
// interrupt status bit positions
`define IRQ_WAKE 0
`define IRQ_MON_RESET 1
`define IRQ_FALLBACK_CHG 2
`define IRQ_RESUME 3
`define IRQ_WIDTH 4
// reset values
`define CTRL_RESET 32'h0000_0008
// counts in stop counter clock cycles
`define LONG_DELAY_CYCLES 13'd4096
`define SHORT_DELAY_CYCLES 13'd16
`endif

// File: hw/stop_exit_pkg.sv
package stop_exit_pkg;
  // sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_RUN = 6'h01,
    ST_STOP = 6'h02,
    ST_XTAL_WAIT = 6'h04,
    ST_FB_WAIT = 6'h08,
    ST_FALLBACK = 6'h10,
    ST_MON_RESET = 6'h20
  } seq_state_t;
  // clock source reported to the rest of the chip
  typedef enum logic [1:0] {
    SRC_CRYSTAL = 2'h0,
    SRC_FALLBACK = 2'h1,
    SRC_NONE = 2'h2
  } clk_src_t;
endpackage : stop_exit_pkg

// File: hw/tick_divider.sv
`timescale 1ns/100ps
// makes the stop counter clock tick from the slow-mode divider setting
module tick_divider #(
  parameter int W = 6
) (
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, active low
  input wire logic [W-1:0] slow_div, // divider setting, 0 bypasses
  output logic tick // one-cycle counter clock pulse
);
  logic [W+1:0] cnt_reg;
  logic [W+1:0] limit;
  // counter clock is half the slow clock: period 4*slow, or 2 when bypassed
  assign limit = (slow_div == '0) ? (W+2)'(1)
                 : {slow_div, 2'b00} - (W+2)'(1);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= '0;
      tick <= 1'b0;
    end else if (cnt_reg >= limit) begin
      cnt_reg <= '0;
      tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + (W+2)'(1);
      tick <= 1'b0;
    end
  end
endmodule : tick_divider

// File: hw/pseudo_stop_exit_sequencer.sv
`timescale 1ns/100ps
`include "stop_exit_cfg.svh"
// Behaviour
// - no fallback disable, no delay: immediate exit
// - fallback recovery restarts vco, fallback clock
// - disabled fallback plus monitor: stop means reset
// - no fallback, no monitor: never fallback
// - crystal path with delay waits 4096 ticks
// - crystal path without delay waits 16 ticks
// - pll supply present: fallback after any reset
// - fallback with delay exits in fallback mode
// - counter clock from slow-mode divider setting
// - oscillator hold turns stop into pseudo-stop
// - reset, irqs, key or can wake exit stop
// - fallback checks monitor every 4096 counts
module pseudo_stop_exit_sequencer #(
  parameter int SLOW_W = 6
) (
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, active low
  input wire logic [11:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [11:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic pll_supply, // pll supply present, pin
  input wire logic crystal_present, // clock monitor sees crystal, pin
  input wire logic irq_wake, // maskable irq wake, pin
  input wire logic nonmaskable_wake_irq, // non-maskable wake, pin
  input wire logic key_wake_a, // key wake port a, pin
  input wire logic key_wake_b, // key wake port b, pin
  input wire logic can_wake, // can controller wake, pin
  output logic in_stop, // core held in stop
  output logic osc_running, // oscillator kept running
  output logic vco_enable, // vco running
  output logic fallback_active, // fallback clock feeds core
  output stop_exit_pkg::clk_src_t core_clk_src, // clock routed to core
  output logic monitor_reset, // clock-monitor reset request
  output logic irq // level interrupt
);
  import stop_exit_pkg::*;

  seq_state_t state_reg, state_next;
  logic [31:0] ctrl_reg;
  logic [`IRQ_WIDTH-1:0] ista_reg, ien_reg;
  logic [12:0] cnt_reg;
  logic pseudo_reg;
  logic [2:0] settle_reg;
  logic tick;
  logic [4:0] s1_reg, s2_reg, s3_reg, pins_reg;
  logic aw_ok_reg, w_ok_reg;
  logic [11:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic wr_fire;
  logic stop_cmd, flag_clr;
  logic wake;
  logic fb_dis, mon_en, dly;
  logic [`IRQ_WIDTH-1:0] ev;

  assign fb_dis = ctrl_reg[`CTRL_FALLBACK_DISABLE] | ~pins_reg[0];
  assign mon_en = ctrl_reg[`CTRL_MONITOR_ENABLE]
                  | ctrl_reg[`CTRL_FORCED_MONITOR];
  assign dly = ctrl_reg[`CTRL_EXIT_DELAY];

  // three-stage pin synchroniser; a change counts when stages 2 and 3 agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      pins_reg <= '0;
    end else begin
      s1_reg <= {can_wake, key_wake_b | key_wake_a,
                 irq_wake | nonmaskable_wake_irq, crystal_present,
                 pll_supply};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < 5; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          pins_reg[i] <= s3_reg[i];
        end
      end
    end
  end

  // any wake source ends stop; reset wakes by itself
  assign wake = pins_reg[2] | pins_reg[3] | pins_reg[4];

  // stop counter clock from the slow divider field
  tick_divider #(.W(SLOW_W)) i_tick_divider (
    .aclk(aclk),
    .aresetn(aresetn),
    .slow_div(ctrl_reg[`CTRL_SLOW_LSB +: SLOW_W]),
    .tick(tick)
  );

  // axi write: address and data latched independently, then one response
  assign wr_fire = aw_ok_reg & w_ok_reg & ~s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_reg <= 1'b0;
      w_ok_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      s_axi_awready <= ~aw_ok_reg & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~w_ok_reg & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_ok_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_ok_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
      end
      if (wr_fire) begin
        aw_ok_reg <= 1'b0;
        w_ok_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awaddr_reg == `OFF_CTRL || awaddr_reg == `OFF_IRQ_EN
            || awaddr_reg == `OFF_IRQ_CLR || awaddr_reg == `OFF_CMD) begin
          s_axi_bresp <= 2'h0;
        end else begin
          s_axi_bresp <= 2'h2;
        end
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register writes; fallback-disable only settable in low byte lane
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `CTRL_RESET;
      ien_reg <= '0;
    end else if (wr_fire) begin
      if (awaddr_reg == `OFF_CTRL) begin
        for (int b = 0; b < 4; b++) begin
          if (s_axi_wstrb[b]) begin
            ctrl_reg[b*8 +: 8] <= wdata_reg[b*8 +: 8];
          end
        end
      end else if (awaddr_reg == `OFF_IRQ_EN && s_axi_wstrb[0]) begin
        ien_reg <= wdata_reg[`IRQ_WIDTH-1:0];
      end
    end
  end

  assign stop_cmd = wr_fire && awaddr_reg == `OFF_CMD && s_axi_wstrb[0]
                    && wdata_reg[`CMD_STOP];
  assign flag_clr = wr_fire && awaddr_reg == `OFF_IRQ_CLR
                    && s_axi_wstrb[0];

  // sequencer next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        if (stop_cmd) begin
          if (fb_dis && mon_en) begin
            state_next = ST_MON_RESET;
          end else begin
            state_next = ST_STOP;
          end
        end
      end
      ST_STOP: begin
        if (wake) begin
          if (fb_dis) begin
            state_next = ST_XTAL_WAIT;
          end else if (dly) begin
            state_next = ST_FB_WAIT;
          end else begin
            state_next = ST_FALLBACK;
          end
        end
      end
      ST_XTAL_WAIT: begin
        // without fallback only the crystal can finish the wait
        if (tick && pins_reg[1]) begin
          if ((dly && cnt_reg == `LONG_DELAY_CYCLES - 13'd1)
              || (!dly && cnt_reg == `SHORT_DELAY_CYCLES - 13'd1)) begin
            state_next = ST_RUN;
          end
        end
      end
      ST_FB_WAIT: begin
        if (tick && cnt_reg == `LONG_DELAY_CYCLES - 13'd1) begin
          state_next = pins_reg[1] ? ST_RUN : ST_FALLBACK;
        end
      end
      ST_FALLBACK: begin
        if (tick && cnt_reg == `LONG_DELAY_CYCLES - 13'd1
            && pins_reg[1]) begin
          state_next = ST_RUN;
        end
      end
      ST_MON_RESET: begin
        state_next = ST_MON_RESET; // held until system reset
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  // after any reset the block starts in fallback if the pll supply exists;
  // the supply pin is trusted only once the synchroniser has settled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_FB_WAIT;
    end else if (state_reg == ST_FB_WAIT && !pins_reg[0]
                 && settle_reg == 3'd4) begin
      state_reg <= ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // cycles the pin synchroniser needs to refill after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      settle_reg <= '0;
    end else if (settle_reg != 3'd5) begin
      settle_reg <= settle_reg + 3'd1;
    end
  end

  // 13-stage counter, cleared on wake and on every 4096 check
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= '0;
    end else if (state_reg == ST_STOP || state_reg == ST_RUN) begin
      cnt_reg <= '0;
    end else if (tick) begin
      if (cnt_reg == `LONG_DELAY_CYCLES - 13'd1) begin
        cnt_reg <= '0;
      end else begin
        cnt_reg <= cnt_reg + 13'd1;
      end
    end
  end

  // remember whether this stop keeps the oscillator going
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pseudo_reg <= 1'b0;
    end else if (state_reg == ST_RUN && stop_cmd) begin
      pseudo_reg <= ctrl_reg[`CTRL_OSC_HOLD];
    end
  end

  // events for sticky status
  always_comb begin
    ev = '0;
    ev[`IRQ_WAKE] = state_reg == ST_STOP && wake;
    ev[`IRQ_MON_RESET] = state_reg == ST_RUN && state_next == ST_MON_RESET;
    ev[`IRQ_FALLBACK_CHG] = (state_next == ST_FALLBACK)
                            != (state_reg == ST_FALLBACK);
    ev[`IRQ_RESUME] = state_reg != ST_RUN && state_next == ST_RUN;
  end

  // sticky status; a new event beats a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ista_reg <= '0;
    end else if (flag_clr) begin
      ista_reg <= (ista_reg & ~wdata_reg[`IRQ_WIDTH-1:0]) | ev;
    end else begin
      ista_reg <= ista_reg | ev;
    end
  end

  // registered outputs toward the clock generator
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_stop <= 1'b0;
      osc_running <= 1'b1;
      vco_enable <= 1'b0;
      fallback_active <= 1'b0;
      core_clk_src <= SRC_CRYSTAL;
      monitor_reset <= 1'b0;
      irq <= 1'b0;
    end else begin
      in_stop <= state_next == ST_STOP || state_next == ST_MON_RESET
                 || state_next == ST_XTAL_WAIT;
      osc_running <= state_next != ST_STOP || pseudo_reg;
      vco_enable <= state_next == ST_FB_WAIT
                    || state_next == ST_FALLBACK;
      fallback_active <= state_next == ST_FALLBACK;
      if (state_next == ST_FALLBACK || state_next == ST_FB_WAIT) begin
        core_clk_src <= SRC_FALLBACK;
      end else if (state_next == ST_RUN) begin
        core_clk_src <= SRC_CRYSTAL;
      end else begin
        core_clk_src <= SRC_NONE;
      end
      monitor_reset <= state_next == ST_MON_RESET;
      irq <= |(ista_reg & ien_reg);
    end
  end

  // axi read: one beat, address decoded by if chain
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        if (s_axi_araddr == `OFF_CTRL) begin
          s_axi_rdata <= ctrl_reg;
        end else if (s_axi_araddr == `OFF_STATUS) begin
          s_axi_rdata <= {20'h0, pins_reg[1], pins_reg[0], 4'h0,
                          state_reg};
        end else if (s_axi_araddr == `OFF_IRQ_STAT) begin
          s_axi_rdata <= {{(32-`IRQ_WIDTH){1'b0}}, ista_reg};
        end else if (s_axi_araddr == `OFF_IRQ_EN) begin
          s_axi_rdata <= {{(32-`IRQ_WIDTH){1'b0}}, ien_reg};
        end else if (s_axi_araddr == `OFF_IRQ_CLR
                     || s_axi_araddr == `OFF_CMD) begin
          s_axi_rdata <= '0;
        end else begin
          s_axi_rdata <= '0;
          s_axi_rresp <= 2'h2;
        end
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : pseudo_stop_exit_sequencer

// File: dv/pseudo_stop_exit_sequencer_asserts.sv
`timescale 1ns/100ps
// watches the sequencer's clock-control outputs at its ports
module seq_checker
  import stop_exit_pkg::*;
(
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, active low
  input wire logic pll_supply, // pll supply pin
  input wire logic in_stop, // core held in stop
  input wire logic osc_running, // oscillator kept running
  input wire logic vco_enable, // vco running
  input wire logic fallback_active, // fallback feeds core
  input wire stop_exit_pkg::clk_src_t core_clk_src, // core clock
  input wire logic monitor_reset // monitor reset request
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // only a fresh reset may leave the monitor reset
  property p_mon_hold;
    monitor_reset |=> monitor_reset;
  endproperty
  a_mon_hold: assert property (p_mon_hold)
    else $error("monitor reset dropped");
  property p_mon_stop;
    monitor_reset |-> in_stop && !fallback_active;
  endproperty
  a_mon_stop: assert property (p_mon_stop)
    else $error("monitor reset while running");
  property p_fb_vco;
    fallback_active |-> vco_enable;
  endproperty
  a_fb_vco: assert property (p_fb_vco)
    else $error("fallback without vco");
  property p_fb_src;
    fallback_active |-> core_clk_src == SRC_FALLBACK;
  endproperty
  a_fb_src: assert property (p_fb_src)
    else $error("fallback mode on wrong clock");
  property p_fb_run;
    fallback_active |-> !in_stop;
  endproperty
  a_fb_run: assert property (p_fb_run)
    else $error("fallback mode while core stopped");
  // the oscillator stops only while in_stop is set
  property p_osc_hold;
    !osc_running |-> in_stop;
  endproperty
  a_osc_hold: assert property (p_osc_hold)
    else $error("oscillator off outside stop");
  // without supply the sync has long settled after eight cycles
  property p_nopll;
    (!pll_supply)[*8] |-> !fallback_active && !vco_enable;
  endproperty
  a_nopll: assert property (p_nopll)
    else $error("fallback used without pll supply");
  property p_xtal_exit;
    $fell(in_stop) && !vco_enable |-> core_clk_src == SRC_CRYSTAL;
  endproperty
  a_xtal_exit: assert property (p_xtal_exit)
    else $error("resume not on crystal clock");
endmodule : seq_checker

bind pseudo_stop_exit_sequencer seq_checker i_seq_checker (
  .aclk(aclk), .aresetn(aresetn), .pll_supply(pll_supply),
  .in_stop(in_stop), .osc_running(osc_running),
  .vco_enable(vco_enable), .fallback_active(fallback_active),
  .core_clk_src(core_clk_src), .monitor_reset(monitor_reset)
);

// File: dv/testbench.sv
`timescale 1ns/100ps
`include "stop_exit_cfg.svh"
// drives the sequencer over its register bus and wake pins
module testbench;
  import stop_exit_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0, pll = 1'h0;
  logic xtal = 1'h1; // clean clock source when present
  logic [4:0] wake = 5'h0;
  logic awready, wready, bvalid, arready, rvalid, in_stop;
  logic osc_running, vco_enable, fallback_active, monitor_reset, irq;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  clk_src_t core_clk_src;
  int errors = 0, n_tests = 0, c;

  always #5 aclk = ~aclk;

  pseudo_stop_exit_sequencer i_pseudo_stop_exit_sequencer (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pll_supply(pll), .crystal_present(xtal),
    .irq_wake(wake[0]), .nonmaskable_wake_irq(wake[1]),
    .key_wake_a(wake[2]), .key_wake_b(wake[3]), .can_wake(wake[4]),
    .in_stop(in_stop), .osc_running(osc_running),
    .vco_enable(vco_enable), .fallback_active(fallback_active),
    .core_clk_src(core_clk_src), .monitor_reset(monitor_reset),
    .irq(irq)
  );

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] v,
                    output logic [1:0] rs);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1 && n < 100);
    rs = bresp;
    bready <= 1'h0;
    if (n >= 100) errors++;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] v,
                    output logic [1:0] rs);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1 && n < 100);
    v = rdata;
    rs = rresp;
    rready <= 1'h0;
    if (n >= 100) errors++;
    @(posedge aclk);
  endtask : rd

  // stop, pulse one wake source, time the exit from the pin edge
  task automatic stop_exit(input logic [31:0] ctrl, input int src,
                           input int lo, input int hi);
    wr(`OFF_CTRL, ctrl, r);
    wr(`OFF_CMD, 32'h1, r);
    chk("in_stop", 32'h1, in_stop);
    chk("osc_running", ctrl[4], osc_running);
    wake[src] <= 1'h1;
    repeat (4) @(posedge aclk);
    wake <= 5'h0;
    c = 4;
    while (in_stop !== 1'h0 && c < hi + 20) begin
      @(posedge aclk);
      c++;
    end
    chk("exit_cycles", 32'h1, c >= lo && c <= hi);
    $display("stop exit via source %0d after %0d cycles", src, c);
  endtask : stop_exit

  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  // watchdog sized well above the three long 8192-cycle waits
  initial begin
    #400000;
    errors++;
    results;
  end

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (6) @(posedge aclk);
    rd(`OFF_CTRL, d, r);
    chk("ctrl_reset", `CTRL_RESET, d);
    rd(`OFF_STATUS, d, r);
    chk("status_run", 32'h801, d);
    wr(`OFF_STATUS, 32'h0, r);
    chk("status_wr_resp", 32'h2, r);
    rd(12'h100, d, r);
    chk("unmapped_resp", 32'h2, r);
    chk("unmapped_data", 32'h0, d);
    $display("register test done");
    wr(`OFF_IRQ_EN, 32'hf, r);
    // 16 ticks of 2 cycles; source 0 in plain stop
    for (int i = 0; i < 5; i++)
      stop_exit(i ? 32'h11 : 32'h01, i, 32, 46);
    rd(`OFF_IRQ_STAT, d, r);
    chk("irq_stat", 32'h9, d);
    chk("irq", 32'h1, irq);
    wr(`OFF_IRQ_EN, 32'h0, r);
    chk("irq_masked", 32'h0, irq);
    wr(`OFF_IRQ_EN, 32'hf, r);
    wr(`OFF_IRQ_CLR, 32'hf, r);
    rd(`OFF_IRQ_STAT, d, r);
    chk("irq_cleared", 32'h0, d);
    chk("irq_low", 32'h0, irq);
    $display("interrupt test done");
    stop_exit(32'h111, 2, 64, 80);
    stop_exit(32'h19, 3, 8192, 8210);
    wr(`OFF_CTRL, 32'h3, r);
    wr(`OFF_CMD, 32'h1, r);
    chk("monitor_reset", 32'h1, monitor_reset);
    rd(`OFF_IRQ_STAT, d, r);
    chk("irq_monitor", 32'hb, d);
    $display("monitor reset test done");
    // supply present before reset, so fallback follows reset
    pll <= 1'h1;
    xtal <= 1'h0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (8) @(posedge aclk);
    chk("vco_after_reset", 32'h1, vco_enable);
    // crystal absent at the first check, so fallback mode is entered
    c = 0;
    while (fallback_active !== 1'h1 && c < 9000) begin
      @(posedge aclk);
      c++;
    end
    chk("fallback_entry", 32'h1, c > 8000 && c < 8250);
    xtal <= 1'h1;
    c = 0;
    while (fallback_active !== 1'h0 && c < 9000) begin
      @(posedge aclk);
      c++;
    end
    chk("fallback_wait", 32'h1, c > 8000 && c < 8250);
    chk("vco_off", 32'h0, vco_enable);
    stop_exit(32'h10, 4, 0, 12);
    chk("vco_restart", 32'h1, vco_enable);
    chk("core_src", SRC_FALLBACK, core_clk_src);
    $display("fallback test done");
    results;
  end
endmodule : testbench
